/* src/cds_pkg.sv */
// Constants, types and helpers shared by the clock divider with switchback.
// Assumes a single system clock with synchronous reset.
package cds_pkg;

  // Divider field encodings (oscillator clocks per machine cycle)
  localparam logic [1:0] DIV_RSVD  = 2'h0;
  localparam logic [1:0] DIV4      = 2'h1;
  localparam logic [1:0] DIV64     = 2'h2;
  localparam logic [1:0] DIV1024   = 2'h3;
  localparam logic [1:0] DIV_RESET = DIV4;

  // Oscillator clocks per internal phase cycle
  localparam logic [8:0] PH_CLK_DIV4    = 9'h001;
  localparam logic [8:0] PH_CLK_DIV64   = 9'h010;
  localparam logic [8:0] PH_CLK_DIV1024 = 9'h100;

  // Rate derivation counts
  localparam logic [1:0] MC_PER_SLOW_COUNT = 2'h3;
  localparam logic [4:0] BIT_MC_NORMAL     = 5'h10;
  localparam logic [4:0] BIT_MC_DOUBLE     = 5'h08;
  localparam logic [1:0] DEFER_INSTR       = 2'h2;

  // Register byte offsets
  localparam logic [11:0] OFS_POWER_CTRL  = 12'h000;
  localparam logic [11:0] OFS_TIMER_RATE  = 12'h004;
  localparam logic [11:0] OFS_SERIAL_CTRL = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00c;

  // Field positions
  localparam int POS_DIV_LO    = 6;
  localparam int POS_FAST_RET  = 5;
  localparam int POS_TSEL      = 0;
  localparam int POS_RXEN      = 0;
  localparam int POS_BAUD_DBL  = 2;
  localparam int POS_ST_DIV    = 0;
  localparam int POS_ST_PHASE  = 2;
  localparam int POS_ST_INT    = 6;
  localparam int POS_ST_DEFER  = 7;

  // Reset values
  localparam logic       FAST_RET_RESET = 1'h0;
  localparam logic [2:0] TSEL_RESET     = 3'h0;
  localparam logic [1:0] RXEN_RESET     = 2'h0;
  localparam logic       BAUD_DBL_RESET = 1'h0;

  typedef enum logic [3:0] {
    PH1 = 4'h1,
    PH2 = 4'h2,
    PH3 = 4'h4,
    PH4 = 4'h8
  } cds_phase_e;

  function automatic logic [8:0] phase_len(input logic [1:0] d);
    case (d)
      DIV64:   phase_len = PH_CLK_DIV64;
      DIV1024: phase_len = PH_CLK_DIV1024;
      default: phase_len = PH_CLK_DIV4;
    endcase
  endfunction

  function automatic logic is_reduced(input logic [1:0] d);
    is_reduced = (d == DIV64) || (d == DIV1024);
  endfunction

endpackage

/* src/cds_phase_gen.sv */
// Four-phase machine cycle generator with a stretchable phase length.
// Assumes phaseLen is 1 to 256 oscillator clocks.
`timescale 1ns/10ps
module cds_phase_gen (
  input  wire logic               clk_sys,     // System clock
  input  wire logic               srst,        // Sync reset
  input  wire logic [8:0]         phaseLen,    // Clocks per phase
  output logic                    phaseTick,   // Last clock of a phase
  output cds_pkg::cds_phase_e     phase,       // Current phase
  output logic                    machineTick  // Last clock of cycle
);

  typedef struct packed {
    logic [7:0]          cnt;
    cds_pkg::cds_phase_e ph;
  } cds_pg_s;

  cds_pg_s st;
  cds_pg_s next_st;

  // Compare with >= so a shortened length ends the phase at once
  assign phaseTick   = ({1'b0, st.cnt} >= (phaseLen - 9'h001));
  assign machineTick = phaseTick && (st.ph == cds_pkg::PH4);
  assign phase       = st.ph;

  always_comb begin
    next_st = st;
    if (phaseTick) begin
      next_st.cnt = 8'h00;
      unique case (st.ph)
        cds_pkg::PH1: next_st.ph = cds_pkg::PH2;
        cds_pkg::PH2: next_st.ph = cds_pkg::PH3;
        cds_pkg::PH3: next_st.ph = cds_pkg::PH4;
        cds_pkg::PH4: next_st.ph = cds_pkg::PH1;
        default:      next_st.ph = cds_pkg::PH1;
      endcase
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{cnt: 8'h00, ph: cds_pkg::PH1};
    end else begin
      st <= next_st;
    end
  end

endmodule // cds_phase_gen

/* src/cds_rate_ticks.sv */
// Timer, baud and serial bit enables derived from the phase timing.
// Assumes one-cycle phase and machine strobes from the phase generator.
`timescale 1ns/10ps
module cds_rate_ticks (
  input  wire logic                clk_sys,     // System clock
  input  wire logic                srst,        // Sync reset
  input  wire logic                phaseTick,   // Phase end strobe
  input  cds_pkg::cds_phase_e      phase,       // Current phase
  input  wire logic                machineTick, // Machine cycle end
  input  wire logic [2:0]          timerSel,    // 1: per machine cycle
  input  wire logic                baudDbl,     // Double rate bit
  output logic [2:0]               timerTick,   // Timer count enables
  output logic                     baudTick,    // Second or fourth phase end
  output logic                     bitTick      // Serial mode 2 bit
);

  typedef struct packed {
    logic [1:0] mc3;
    logic [4:0] bitCnt;
    logic [2:0] tmr;
    logic       baud;
    logic       bitT;
  } cds_rt_s;

  cds_rt_s st;
  cds_rt_s next_st;
  logic    slowTick;
  logic    bitEnd;

  assign slowTick  = machineTick && (st.mc3 == (cds_pkg::MC_PER_SLOW_COUNT - 2'h1));
  assign bitEnd    = st.bitCnt == ((baudDbl ? cds_pkg::BIT_MC_DOUBLE
                                            : cds_pkg::BIT_MC_NORMAL) - 5'h01);
  assign timerTick = st.tmr;
  assign baudTick  = st.baud;
  assign bitTick   = st.bitT;

  always_comb begin
    next_st = st;
    if (machineTick) begin
      next_st.mc3    = slowTick ? 2'h0 : st.mc3 + 2'h1;
      next_st.bitCnt = bitEnd ? 5'h00 : st.bitCnt + 5'h01;
    end
    for (int i = 0; i < 3; i++) begin
      next_st.tmr[i] = timerSel[i] ? machineTick : slowTick;
    end
    // Every second phase, independent of the timer select
    next_st.baud = phaseTick && (phase == cds_pkg::PH2 || phase == cds_pkg::PH4);
    next_st.bitT = machineTick && bitEnd;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // cds_rate_ticks

/* src/cds_clock_divider.sv */
// Clock rate divider with hardware switchback, APB register slave.
// Assumes core event strobes are one-cycle pulses synchronous to clk_sys.
`timescale 1ns/10ps
module cds_clock_divider (
  input  wire logic        clk_sys,       // System clock
  input  wire logic        srst,          // Sync reset
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB write
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        intAck,        // Interrupt acknowledged
  input  wire logic        intCtrlWrite,  // Enable/priority reg write
  input  wire logic        instrEnd,      // Instruction completes
  input  wire logic [1:0]  rxLine,        // Serial receive lines
  input  wire logic [1:0]  txLoad,        // Transmit buffer written
  input  wire logic        wdtReset,      // Watchdog reset
  input  wire logic        porReset,      // Power-on reset
  input  wire logic        extReset,      // External reset
  output logic [1:0]       divSel,        // Divider field
  output logic             phaseTick,     // Phase end strobe
  output logic [3:0]       phase,         // One-hot phase
  output logic             machineTick,   // Machine cycle end
  output logic [2:0]       timerTick,     // Timer count enables
  output logic             baudTick,      // Baud rate enable
  output logic             bitTick        // Mode 2 bit enable
);

  typedef struct packed {
    logic [1:0]  divSel;
    logic        fastRet;
    logic [2:0]  timerSel;
    logic [1:0]  rxEn;
    logic        baudDbl;
    logic [1:0]  rxPrev;
    logic        intPend;
    logic [1:0]  txPend;
    logic [1:0]  defer;
    logic [31:0] rdata;
    logic [8:0]  gap;
    logic        modeSame;
  } cds_state_s;

  cds_state_s          st;
  cds_state_s          next_st;
  cds_pkg::cds_phase_e ph;
  logic                setup;
  logic                wr;
  logic                wrPower;
  logic                mapped;
  logic [1:0]          rxFall;
  logic [1:0]          newDiv;
  logic                divLegal;
  logic                rxSw;
  logic                txApply;
  logic                intApply;
  logic                hwReset;
  logic                swEvent;

  cds_phase_gen u_phase (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .phaseLen    (cds_pkg::phase_len(st.divSel)),
    .phaseTick   (phaseTick),
    .phase       (ph),
    .machineTick (machineTick)
  );

  cds_rate_ticks u_ticks (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .phaseTick   (phaseTick),
    .phase       (ph),
    .machineTick (machineTick),
    .timerSel    (st.timerSel),
    .baudDbl     (st.baudDbl),
    .timerTick   (timerTick),
    .baudTick    (baudTick),
    .bitTick     (bitTick)
  );

  assign phase   = ph;
  assign divSel  = st.divSel;
  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // APB decode
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign wrPower = wr && (paddr == cds_pkg::OFS_POWER_CTRL);
  assign mapped  = (paddr == cds_pkg::OFS_POWER_CTRL) ||
                   (paddr == cds_pkg::OFS_TIMER_RATE) ||
                   (paddr == cds_pkg::OFS_SERIAL_CTRL) ||
                   (paddr == cds_pkg::OFS_STATUS);

  // Divider write legality: div4 always, reduced only from div4
  assign newDiv   = pwdata[cds_pkg::POS_DIV_LO +: 2];
  assign divLegal = (newDiv == cds_pkg::DIV4) ||
                    ((st.divSel == cds_pkg::DIV4) &&
                     cds_pkg::is_reduced(newDiv));

  // Switchback sources; no serial done flag enters here
  assign rxFall   = st.rxPrev & ~rxLine;
  assign rxSw     = st.fastRet && |(rxFall & st.rxEn);
  assign txApply  = st.fastRet && instrEnd &&
                    |(st.txPend | txLoad);
  assign intApply = st.fastRet && st.intPend &&
                    machineTick && (st.defer == 2'h0);
  assign hwReset  = wdtReset || porReset || extReset;
  assign swEvent  = rxSw || txApply || intApply || hwReset;

  always_comb begin
    next_st = st;
    next_st.rxPrev = rxLine;

    // Register writes
    if (wrPower) begin
      next_st.fastRet = pwdata[cds_pkg::POS_FAST_RET];
      if (divLegal) begin
        next_st.divSel = newDiv;
      end
    end
    if (wr && paddr == cds_pkg::OFS_TIMER_RATE) begin
      next_st.timerSel = pwdata[cds_pkg::POS_TSEL +: 3];
    end
    if (wr && paddr == cds_pkg::OFS_SERIAL_CTRL) begin
      next_st.rxEn    = pwdata[cds_pkg::POS_RXEN +: 2];
      next_st.baudDbl = pwdata[cds_pkg::POS_BAUD_DBL];
    end

    // Deferral after enable or priority write, new write restarts it
    if (intCtrlWrite) begin
      next_st.defer = cds_pkg::DEFER_INSTR;
    end else if (instrEnd && st.defer != 2'h0) begin
      next_st.defer = st.defer - 2'h1;
    end

    // Pending events: a new acknowledge wins over the clear; a load at instrEnd is not kept pending
    next_st.intPend = (st.intPend && !intApply) ||
                      (intAck && st.fastRet);
    next_st.txPend  = (txApply ? 2'h0 : st.txPend) |
                      (st.fastRet && !instrEnd ? txLoad : 2'h0);
    if (!st.fastRet) begin
      next_st.intPend = 1'b0;
      next_st.txPend  = 2'h0;
    end

    // Hardware return overrides a same-cycle software write
    if (swEvent) begin
      next_st.divSel = cds_pkg::DIV4;
    end

    // Read data captured in setup phase
    if (setup) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        cds_pkg::OFS_POWER_CTRL: begin
          next_st.rdata[cds_pkg::POS_DIV_LO +: 2] = st.divSel;
          next_st.rdata[cds_pkg::POS_FAST_RET]    = st.fastRet;
        end
        cds_pkg::OFS_TIMER_RATE: begin
          next_st.rdata[cds_pkg::POS_TSEL +: 3] = st.timerSel;
        end
        cds_pkg::OFS_SERIAL_CTRL: begin
          next_st.rdata[cds_pkg::POS_RXEN +: 2] = st.rxEn;
          next_st.rdata[cds_pkg::POS_BAUD_DBL]  = st.baudDbl;
        end
        cds_pkg::OFS_STATUS: begin
          next_st.rdata[cds_pkg::POS_ST_DIV +: 2]   = st.divSel;
          next_st.rdata[cds_pkg::POS_ST_PHASE +: 4] = ph;
          next_st.rdata[cds_pkg::POS_ST_INT]        = st.intPend;
          next_st.rdata[cds_pkg::POS_ST_DEFER]      = st.defer != 2'h0;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Phase length watch for checking
    next_st.gap      = phaseTick ? 9'h000 : st.gap + 9'h001;
    next_st.modeSame = phaseTick ? (next_st.divSel == st.divSel)
                                 : (st.modeSame && next_st.divSel == st.divSel);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st          <= '0;
      st.divSel   <= cds_pkg::DIV_RESET;
      st.fastRet  <= cds_pkg::FAST_RET_RESET;
      st.timerSel <= cds_pkg::TSEL_RESET;
      st.rxEn     <= cds_pkg::RXEN_RESET;
      st.baudDbl  <= cds_pkg::BAUD_DBL_RESET;
      st.rxPrev   <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_reset_div4;
    $fell(srst) |-> (divSel == cds_pkg::DIV4) && (st.timerSel == 3'h0);
  endproperty
  a_reset_div4: assert property (p_reset_div4)
    else $error("Divider or timer select wrong after reset");

  property p_illegal_write;
    wrPower && cds_pkg::is_reduced(st.divSel) &&
    cds_pkg::is_reduced(newDiv) && !swEvent |=> $stable(divSel);
  endproperty
  a_illegal_write: assert property (p_illegal_write)
    else $error("Direct reduced to reduced change was accepted");

  property p_rx_switch;
    st.fastRet && |(rxFall & st.rxEn) |=> divSel == cds_pkg::DIV4;
  endproperty
  a_rx_switch: assert property (p_rx_switch)
    else $error("Start bit did not return divider to div4");

  property p_tx_switch;
    st.fastRet && (st.txPend != 2'h0) && instrEnd |=> divSel == cds_pkg::DIV4;
  endproperty
  a_tx_switch: assert property (p_tx_switch)
    else $error("Buffer load did not return divider at next instruction");

  property p_int_switch;
    st.fastRet && st.intPend && machineTick && st.defer == 2'h0
      |=> divSel == cds_pkg::DIV4 && ph == cds_pkg::PH1;
  endproperty
  a_int_switch: assert property (p_int_switch)
    else $error("Interrupt return missed first phase start");

  property p_defer;
    st.intPend && st.defer != 2'h0 && !rxSw && !txApply &&
    !hwReset && !wrPower |=> $stable(divSel);
  endproperty
  a_defer: assert property (p_defer)
    else $error("Interrupt return not deferred");

  property p_swb_off;
    !st.fastRet && !hwReset && !wrPower |=> $stable(divSel);
  endproperty
  a_swb_off: assert property (p_swb_off)
    else $error("Divider changed with fast return disabled");

  property p_hw_reset;
    hwReset |=> divSel == cds_pkg::DIV4;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("Reset source did not return divider");

  property p_phase_len;
    phaseTick && st.modeSame |-> st.gap == cds_pkg::phase_len(divSel) - 9'h001;
  endproperty
  a_phase_len: assert property (p_phase_len)
    else $error("Phase length wrong for divider");

  property p_machine;
    machineTick |=> ph == cds_pkg::PH1 ##0 $past(ph) == cds_pkg::PH4;
  endproperty
  a_machine: assert property (p_machine)
    else $error("Machine cycle did not wrap from last phase");

  property p_div4_write;
    wrPower && newDiv == cds_pkg::DIV4 |=> divSel == cds_pkg::DIV4;
  endproperty
  a_div4_write: assert property (p_div4_write)
    else $error("Divide by four write was not accepted");

  property p_reduced_entry;
    wrPower && st.divSel == cds_pkg::DIV4 && cds_pkg::is_reduced(newDiv) && !swEvent
      |=> divSel == $past(newDiv);
  endproperty
  a_reduced_entry: assert property (p_reduced_entry)
    else $error("Reduced mode entry from divide by four was lost");

  property p_reserved_write;
    wrPower && newDiv == cds_pkg::DIV_RSVD && !swEvent |=> $stable(divSel);
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("Reserved divider code was accepted");

  property p_div_source;
    $changed(divSel) |-> $past(wrPower) || $past(swEvent) || $past(srst);
  endproperty
  a_div_source: assert property (p_div_source)
    else $error("Divider changed without a write or return event");

  property p_tx_pending;
    st.fastRet && txLoad != 2'h0 && !instrEnd |=> st.txPend != 2'h0;
  endproperty
  a_tx_pending: assert property (p_tx_pending)
    else $error("Buffer load did not leave a pending return");

  property p_int_pending;
    st.fastRet && intAck |=> st.intPend;
  endproperty
  a_int_pending: assert property (p_int_pending)
    else $error("Acknowledged interrupt did not become pending");

  property p_baud_tick;
    baudTick |-> $past(phaseTick) &&
                 ($past(ph) == cds_pkg::PH2 || $past(ph) == cds_pkg::PH4);
  endproperty
  a_baud_tick: assert property (p_baud_tick)
    else $error("Baud enable off the second or fourth phase end");

  property p_timer_tick;
    timerTick != 3'h0 |-> $past(machineTick);
  endproperty
  a_timer_tick: assert property (p_timer_tick)
    else $error("Timer enable without a machine cycle end");

endmodule // cds_clock_divider

/* tb/cds_partner.sv */
// Core-side model: interrupt controller, serial lines, instruction flow.
// Assumes one instruction per machine cycle, strobed on machineTick.
`timescale 1ns/10ps
module cds_partner (
  input  wire logic       clk_sys,      // System clock
  input  wire logic       machineTick,  // Machine cycle end
  output logic            intAck,       // Interrupt acknowledged
  output logic            intCtrlWrite, // Enable/priority write
  output logic            instrEnd,     // Instruction completes
  output logic [1:0]      rxLine,       // Receive lines, idle high
  output logic [1:0]      txLoad        // Transmit buffer written
);
  initial begin
    intAck = 1'h0;
    intCtrlWrite = 1'h0;
    instrEnd = 1'h0;
    rxLine = 2'h3;
    txLoad = 2'h0;
  end

  always @(posedge clk_sys) begin
    instrEnd <= machineTick;
  end

  // Only enabled, unblocked interrupts get acknowledged
  task automatic ack(input logic w);
    @(posedge clk_sys);
    intAck <= 1'h1;
    intCtrlWrite <= w;
    @(posedge clk_sys);
    intAck <= 1'h0;
    intCtrlWrite <= 1'h0;
  endtask

  task automatic start_bit(input int p);
    @(posedge clk_sys);
    rxLine[p] <= 1'h0;
    repeat (8) @(posedge clk_sys);
    rxLine[p] <= 1'h1;
  endtask

  task automatic tx_load(input int p);
    @(posedge clk_sys);
    txLoad[p] <= 1'h1;
    @(posedge clk_sys);
    txLoad <= 2'h0;
  endtask
endmodule // cds_partner

/* tb/clock_divider_switchback_tb.sv */
// Self-checking bench for the clock divider with switchback.
// Assumes cds_clock_divider over APB and the cds_partner core model.
`timescale 1ns/10ps
module clock_divider_switchback_tb;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        intAck, intCtrlWrite, instrEnd, phaseTick, machineTick, baudTick, bitTick;
  logic [1:0]  rxLine, txLoad, divSel;
  logic [2:0]  hr, timerTick;
  logic [3:0]  phase;
  int          failures, comparisons, seed, mdl, fr;

  cds_clock_divider i_cds_clock_divider (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .intAck, .intCtrlWrite, .instrEnd, .rxLine, .txLoad,
    .wdtReset(hr[0]), .porReset(hr[1]), .extReset(hr[2]), .divSel, .phaseTick, .phase,
    .machineTick, .timerTick, .baudTick, .bitTick);
  cds_partner i_cds_partner (.clk_sys, .machineTick, .intAck, .intCtrlWrite, .instrEnd,
    .rxLine, .txLoad);

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t value got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_per(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t period got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) begin
      failures++;
      complete_run();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Unused upper bits get random filler
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, {$random(seed)} & 32'hffffff00 | {24'h0, d});
  endtask

  task automatic setp(input int div, input int f);
    wr(12'h000, 8'((div << 6) | (f << 5)));
    fr = f;
    if (div == 1 || (div >= 2 && mdl == 1)) mdl = div;
  endtask

  task automatic chkdiv();
    apb(1'h0, 12'h000, 32'h0);
    cmp_reg(rd, (mdl << 6) | (fr << 5));
    cmp_reg({30'h0, divSel}, mdl);
  endtask

  function automatic logic tick(input int s);
    case (s)
      0: tick = machineTick;
      1: tick = phaseTick;
      2: tick = timerTick[0];
      3: tick = timerTick[1];
      4: tick = baudTick;
      6: tick = timerTick[2];
      default: tick = bitTick;
    endcase
  endfunction

  task automatic per(input int s, input int exp);
    int k;
    int c;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (tick(s) !== 1'h1 && k < 5000);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (tick(s) !== 1'h1 && c < 20000);
    if (k >= 5000 || c >= 20000) begin
      failures++;
      complete_run();
    end
    cmp_per(c, exp);
  endtask

  task automatic trig(input int k);
    case (k)
      0: i_cds_partner.ack(1'h0);
      1, 2: i_cds_partner.start_bit(k - 1);
      3, 4: i_cds_partner.tx_load(k - 3);
      default: begin
        @(posedge clk_sys);
        hr[k - 5] <= 1'h1;
        @(posedge clk_sys);
        hr <= 3'h0;
      end
    endcase
  endtask

  // Waits for the field to leave divide-by-64, then compares
  task automatic waitdiv();
    int k;
    k = 0;
    while (divSel === 2'h2 && k < 200) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    cmp_reg({30'h0, divSel}, mdl);
  endtask

  initial begin
    #(50 * 100000);
    failures++;
    complete_run();
  end

  initial begin
    seed = 44;
    failures = 0;
    comparisons = 0;
    mdl = 1;
    fr = 0;
    srst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hr = 3'h0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'h0;
    chkdiv();
    apb(1'h0, 12'h004, 32'h0);
    cmp_reg(rd, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    cmp_reg({rd[30:0], serr}, 32'h1);
    per(0, 4);
    per(1, 1);
    per(2, 12);
    per(6, 12);
    per(4, 2);
    per(5, 64);
    wr(12'h004, 8'h01);
    wr(12'h008, 8'h07);
    per(2, 4);
    per(5, 32);
    setp(2, 0);
    chkdiv();
    per(0, 64);
    per(1, 16);
    per(2, 64);
    per(3, 192);
    per(6, 192);
    per(4, 32);
    per(5, 512);
    setp(3, 0);
    chkdiv();
    setp(0, 0);
    chkdiv();
    setp(1, 0);
    setp(3, 0);
    chkdiv();
    per(0, 1024);
    per(3, 3072);
    per(4, 512);
    // Serial idle here, so divider changes are safe
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 8; k++) begin
        setp(1, f);
        setp(2, f);
        trig(k);
        if (f == 1 || k >= 5) mdl = 1;
        waitdiv();
        if (f == 1 && k == 0) cmp_reg({28'h0, phase}, 32'h1);
      end
    end
    wr(12'h008, 8'h04);
    setp(1, 1);
    setp(2, 1);
    trig(1);
    waitdiv();
    wr(12'h008, 8'h07);
    i_cds_partner.ack(1'h1);
    per(0, 64);
    cmp_reg({30'h0, divSel}, mdl);
    mdl = 1;
    waitdiv();
    chkdiv();
    setp(3, 1);
    chkdiv();
    complete_run();
  end
endmodule // clock_divider_switchback_tb
